// [hdl/tdc_dma.sv]
`timescale 1ns/10ps
// Operation
// - Unit cycles: reads times j plus writes times k
// - Word odd or 8-bit bus doubles beats
// - Any even/odd source and destination pairing
// - Enable loads pointer and counter at first transfer
// - Rewriting enable repeats both reloads
// - Source event sets flag regardless of enable
// - Flag cleared just before transfer begins
// - Software writes zero clears, one ignored
// - Peripheral request sets flag with its interrupt
// - Pin edge sets flag, cleared at transfer
// - Same-cycle requests set all flags together
// - Channel zero wins simultaneous requests
// - One CPU access between successive transfers
// - Underflow stops single, reloads counter in repeat mode
// - Underflow raises channel interrupt
// - Pointer write lock and live pointer read
module tdc_dma (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Request sources
  input wire logic [7:2] periph_req,
  input wire logic [1:0] external_request_pin,
  // System bus sharing
  input wire logic cpu_access_done,
  output logic bus_hold,
  output logic xfer_chan,
  output logic [19:0] xfer_src,
  output logic [19:0] xfer_dst,
  // Interrupt
  output logic irq
);
  tdc_pkg::tdc_state_type s; // Registered state
  tdc_pkg::tdc_state_type next_s; // Next state
  logic acc; // First access cycle
  logic wr; // Write commit edge
  logic [1:0] ev; // Request events
  logic start; // Transfer starts now
  logic fin; // Transfer ends now
  logic pick; // Chosen channel
  logic [1:0] uflow; // Counter underflow
  logic [3:0] start_cyc; // Bus cycles of new unit
  logic [19:0] nptr; // Pointer after reload
  logic [7:0] ofs; // Register offset in channel
  logic hit; // Address decoded
  logic c_sel; // Channel of access

  // Beats needed for one access of a unit
  function automatic logic [3:0] beats(input logic byte_unit, input logic bus8,
                                       input logic odd);
    // Word at odd address or over 8-bit bus takes two
    if (!byte_unit && (bus8 || odd)) begin
      beats = tdc_pkg::BEATS_TWO;
    end else begin
      beats = tdc_pkg::BEATS_ONE;
    end
  endfunction

  // Cycle coefficient of a bus class
  function automatic logic [3:0] coef(input logic [1:0] cls);
    if (cls == tdc_pkg::CLS_FAST) begin
      coef = tdc_pkg::COEF_FAST;
    end else if (cls == tdc_pkg::CLS_MUX) begin
      coef = tdc_pkg::COEF_MUX;
    end else begin
      coef = tdc_pkg::COEF_WAIT;
    end
  endfunction

  // Outputs straight from state
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign irq = s.irq;
  assign bus_hold = s.bus_hold;
  assign xfer_chan = s.xfer_chan;
  assign xfer_src = s.xfer_src;
  assign xfer_dst = s.xfer_dst;

  // All next-state logic
  always_comb begin
    next_s = s;
    acc = psel && penable && !s.pready;
    wr = psel && penable && s.pready && pwrite;
    start = 1'b0;
    fin = 1'b0;
    uflow = 2'b00;
    ev = 2'b00;
    start_cyc = 4'h0;
    nptr = tdc_pkg::PTR_RST;
    c_sel = paddr[5];
    ofs = {3'b000, paddr[4:0]};
    hit = 1'b0;
    // Choose channel, zero first
    // fixed priority
    pick = !(s.ch[0].ctrl[tdc_pkg::C_EN] && s.ch[0].req);

    // Source events, all sampled in the same cycle
    // common sampling edge
    for (int c = 0; c < 2; c++) begin
      logic [2:0] sel;
      sel = s.ch[c].ctrl[tdc_pkg::C_SEL +: 3];
      ev[c] = (sel >= tdc_pkg::SEL_PERI) && periph_req[sel];
      // pin falling edge, or both edges
      if (sel == tdc_pkg::SEL_PIN) begin
        ev[c] = s.ch[c].ctrl[tdc_pkg::C_BOTH] ?
                (s.ch[c].pin_prev ^ external_request_pin[c]) :
                (s.ch[c].pin_prev && !external_request_pin[c]);
      end
      if (sel == tdc_pkg::SEL_SOFT && wr && paddr[31:6] == 26'h0 && paddr[5] == c[0] &&
          ofs == tdc_pkg::OFS_CTRL) begin
        ev[c] = pwdata[tdc_pkg::C_SWTRIG];
      end
      next_s.ch[c].pin_prev = external_request_pin[c];
    end

    // Transfer engine
    next_s.irq_stat = s.irq_stat;
    unique case (s.phase)
      tdc_pkg::PH_IDLE: begin
        if (s.ch[pick].ctrl[tdc_pkg::C_EN] && s.ch[pick].req) begin
          start = 1'b1;
          next_s.ch[pick].req = 1'b0;
          nptr = s.ch[pick].wptr;
          if (s.ch[pick].reload_pend) begin
            nptr = s.ch[pick].ctrl[tdc_pkg::C_DST_FWD] ? s.ch[pick].dst : s.ch[pick].src;
            next_s.ch[pick].count = s.ch[pick].reload;
            next_s.ch[pick].reload_pend = 1'b0;
          end
          next_s.ch[pick].wptr = nptr;
          next_s.xfer_src = s.ch[pick].ctrl[tdc_pkg::C_DST_FWD] ? s.ch[pick].src : nptr;
          next_s.xfer_dst = s.ch[pick].ctrl[tdc_pkg::C_DST_FWD] ? nptr : s.ch[pick].dst;
          start_cyc = 4'(beats(s.ch[pick].ctrl[tdc_pkg::C_BYTE], s.ch[pick].ctrl[tdc_pkg::C_BUS8],
                               next_s.xfer_src[0]) * coef(s.ch[pick].ctrl[tdc_pkg::C_RCLS +: 2])
                         + beats(s.ch[pick].ctrl[tdc_pkg::C_BYTE],
                                 s.ch[pick].ctrl[tdc_pkg::C_BUS8], next_s.xfer_dst[0])
                           * coef(s.ch[pick].ctrl[tdc_pkg::C_WCLS +: 2]));
          next_s.cyc = 4'(start_cyc - 4'h1);
          next_s.xfer_chan = pick;
          next_s.bus_hold = 1'b1;
          next_s.phase = tdc_pkg::PH_MOVE;
        end
      end
      tdc_pkg::PH_MOVE: begin
        if (s.cyc == 4'h0) begin
          fin = 1'b1;
          next_s.bus_hold = 1'b0;
          next_s.phase = tdc_pkg::PH_GIVE;
          next_s.ch[s.xfer_chan].wptr = 20'(s.ch[s.xfer_chan].wptr +
            (s.ch[s.xfer_chan].ctrl[tdc_pkg::C_BYTE] ? tdc_pkg::INC_BYTE : tdc_pkg::INC_WORD));
          next_s.ch[s.xfer_chan].count = 16'(s.ch[s.xfer_chan].count - 16'h0001);
          if (s.ch[s.xfer_chan].count == 16'h0000) begin
            uflow[s.xfer_chan] = 1'b1;
            if (s.ch[s.xfer_chan].ctrl[tdc_pkg::C_RPT]) begin
              next_s.ch[s.xfer_chan].count = s.ch[s.xfer_chan].reload;
            end else begin
              next_s.ch[s.xfer_chan].ctrl[tdc_pkg::C_EN] = 1'b0;
            end
          end
        end else begin
          next_s.cyc = 4'(s.cyc - 4'h1);
        end
      end
      tdc_pkg::PH_GIVE: begin
        if (cpu_access_done) begin
          next_s.phase = tdc_pkg::PH_IDLE;
        end
      end
    endcase

    // APB read data and error, captured one cycle into access
    next_s.pready = acc;
    if (acc) begin
      next_s.prdata = 32'h0000_0000;
      hit = (paddr[31:8] == 24'h0) && (paddr[7:6] == 2'b00) && (ofs <= tdc_pkg::OFS_COUNT);
      if (paddr[31:8] == 24'h0 && paddr[7:6] == 2'b00) begin
        if (ofs == tdc_pkg::OFS_SRC) begin
          // live pointer when forward and on
          next_s.prdata[19:0] = (s.ch[c_sel].ctrl[tdc_pkg::C_EN] &&
            !s.ch[c_sel].ctrl[tdc_pkg::C_DST_FWD]) ? s.ch[c_sel].wptr : s.ch[c_sel].src;
        end else if (ofs == tdc_pkg::OFS_DST) begin
          next_s.prdata[19:0] = (s.ch[c_sel].ctrl[tdc_pkg::C_EN] &&
            s.ch[c_sel].ctrl[tdc_pkg::C_DST_FWD]) ? s.ch[c_sel].wptr : s.ch[c_sel].dst;
        end else if (ofs == tdc_pkg::OFS_RELOAD) begin
          next_s.prdata[15:0] = s.ch[c_sel].reload;
        end else if (ofs == tdc_pkg::OFS_CTRL) begin
          next_s.prdata[15:0] = s.ch[c_sel].ctrl;
        end else if (ofs == tdc_pkg::OFS_COUNT) begin
          next_s.prdata[15:0] = s.ch[c_sel].count;
        end
      end else if (paddr[31:8] == 24'h0) begin
        hit = 1'b1;
        if (paddr[7:0] == tdc_pkg::OFS_REQ) begin
          next_s.prdata[1:0] = {s.ch[1].req, s.ch[0].req};
        end else if (paddr[7:0] == tdc_pkg::OFS_IRQ_STAT) begin
          next_s.prdata[1:0] = s.irq_stat;
        end else if (paddr[7:0] == tdc_pkg::OFS_IRQ_EN) begin
          next_s.prdata[1:0] = s.irq_en;
        end else begin
          hit = (paddr[7:0] == tdc_pkg::OFS_IRQ_CLR);
        end
      end
      // Unaligned addresses are unmapped
      hit = hit && (paddr[1:0] == 2'b00);
      next_s.pslverr = !hit;
    end else begin
      next_s.pslverr = 1'b0;
    end

    // APB writes at the completing edge; software beats the engine
    if (wr && !s.pslverr && paddr[31:8] == 24'h0 && paddr[7:6] == 2'b00) begin
      if (ofs == tdc_pkg::OFS_SRC && (!s.ch[c_sel].ctrl[tdc_pkg::C_EN] ||
          !s.ch[c_sel].ctrl[tdc_pkg::C_DST_FWD])) begin
        next_s.ch[c_sel].src = pwdata[19:0];
      end
      if (ofs == tdc_pkg::OFS_DST && (!s.ch[c_sel].ctrl[tdc_pkg::C_EN] ||
          s.ch[c_sel].ctrl[tdc_pkg::C_DST_FWD])) begin
        next_s.ch[c_sel].dst = pwdata[19:0];
      end
      if (ofs == tdc_pkg::OFS_RELOAD) begin
        next_s.ch[c_sel].reload = pwdata[15:0];
      end
      if (ofs == tdc_pkg::OFS_CTRL) begin
        // Trigger bit is a strobe, never stored
        next_s.ch[c_sel].ctrl = pwdata[15:0] & ~(16'h0001 << tdc_pkg::C_SWTRIG);
        // every write of one rearms reloads
        next_s.ch[c_sel].reload_pend = pwdata[tdc_pkg::C_EN];
      end
    end
    if (wr && !s.pslverr && paddr[31:8] == 24'h0) begin
      if (paddr[7:0] == tdc_pkg::OFS_REQ) begin
        next_s.ch[0].req = next_s.ch[0].req && pwdata[0];
        next_s.ch[1].req = next_s.ch[1].req && pwdata[1];
      end
      if (paddr[7:0] == tdc_pkg::OFS_IRQ_CLR) begin
        next_s.irq_stat = s.irq_stat & ~pwdata[1:0];
      end
      if (paddr[7:0] == tdc_pkg::OFS_IRQ_EN) begin
        next_s.irq_en = pwdata[1:0];
      end
    end

    // Hardware sets last so a same-cycle clear never loses an event
    for (int c = 0; c < 2; c++) begin
      // set regardless, merged in one bit
      if (ev[c]) begin
        next_s.ch[c].req = 1'b1;
      end
    end
    next_s.irq_stat = next_s.irq_stat | uflow;
    next_s.irq = |(next_s.irq_stat & next_s.irq_en);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  default clocking dcb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_hold2;
    s.bus_hold [*2] ##1 !s.bus_hold;
  endsequence
  property p_flag_set;
    ev[0] |=> s.ch[0].req;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("request flag not set");
  property p_sw_one;
    wr && paddr == 32'h40 && !s.ch[1].req && !ev[1] |=> !s.ch[1].req;
  endproperty
  a_sw_one: assert property (p_sw_one) else $error("software set flag");
  property p_prio;
    s.phase == tdc_pkg::PH_IDLE && s.ch[0].req && s.ch[1].req && s.ch[0].ctrl[0]
      && s.ch[1].ctrl[0] |=> s.bus_hold && !s.xfer_chan;
  endproperty
  a_prio: assert property (p_prio) else $error("channel one won");
  property p_give;
    $fell(s.bus_hold) |-> s.phase == tdc_pkg::PH_GIVE ##1 !s.bus_hold;
  endproperty
  a_give: assert property (p_give) else $error("bus not returned");
  property p_wait;
    s.phase == tdc_pkg::PH_GIVE && !cpu_access_done |=>
      s.phase == tdc_pkg::PH_GIVE && !s.bus_hold;
  endproperty
  a_wait: assert property (p_wait) else $error("transfer before processor access");
  property p_len;
    start && start_cyc == 4'h2 |=> s_hold2;
  endproperty
  a_len: assert property (p_len) else $error("wrong unit length");
  property p_clear;
    start && !pick && !ev[0] |=> !s.ch[0].req;
  endproperty
  a_clear: assert property (p_clear) else $error("flag kept at start");
  property p_reload;
    start && !pick && s.ch[0].reload_pend && !wr |=> s.ch[0].count == $past(s.ch[0].reload);
  endproperty
  a_reload: assert property (p_reload) else $error("counter not reloaded");
  property p_single;
    uflow[0] && !s.ch[0].ctrl[1] && !wr |=> !s.ch[0].ctrl[0];
  endproperty
  a_single: assert property (p_single) else $error("single mode kept on");
  property p_irq;
    uflow[1] |=> s.irq_stat[1] ##0 (s.irq == s.irq_en[1] || s.irq);
  endproperty
  a_irq: assert property (p_irq) else $error("no underflow status");
endmodule

// [hdl/tdc_pkg.sv]
package tdc_pkg;
  // Register byte offsets, channel one sits one stride above channel zero
  localparam logic [7:0] OFS_SRC = 8'h00;
  localparam logic [7:0] OFS_DST = 8'h04;
  localparam logic [7:0] OFS_RELOAD = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0c;
  localparam logic [7:0] OFS_COUNT = 8'h10;
  localparam logic [7:0] CH_STRIDE = 8'h20;
  localparam logic [7:0] OFS_REQ = 8'h40;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h44;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h48;
  localparam logic [7:0] OFS_IRQ_EN = 8'h4c;
  // Control field positions
  localparam int C_EN = 0;
  localparam int C_RPT = 1;
  localparam int C_BYTE = 2;
  localparam int C_DST_FWD = 3;
  localparam int C_SEL = 5;
  localparam int C_BOTH = 8;
  localparam int C_RCLS = 9;
  localparam int C_WCLS = 11;
  localparam int C_BUS8 = 13;
  localparam int C_SWTRIG = 15;
  // Request source codes; codes 2 to 7 pick a peripheral line
  localparam logic [2:0] SEL_SOFT = 3'h0;
  localparam logic [2:0] SEL_PIN = 3'h1;
  localparam logic [2:0] SEL_PERI = 3'h2;
  // Bus classes and their cycle coefficients
  localparam logic [1:0] CLS_FAST = 2'h0;
  localparam logic [1:0] CLS_MUX = 2'h3;
  localparam logic [3:0] COEF_FAST = 4'h1;
  localparam logic [3:0] COEF_WAIT = 4'h2;
  localparam logic [3:0] COEF_MUX = 4'h3;
  localparam logic [3:0] BEATS_ONE = 4'h1;
  localparam logic [3:0] BEATS_TWO = 4'h2;
  // Pointer steps and reset values
  localparam logic [19:0] INC_BYTE = 20'h00001;
  localparam logic [19:0] INC_WORD = 20'h00002;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [19:0] PTR_RST = 20'h00000;
  localparam logic [15:0] CNT_RST = 16'h0000;

  // Engine phases
  typedef enum logic [1:0] {PH_IDLE, PH_MOVE, PH_GIVE} tdc_phase_type;

  // One channel's state
  typedef struct packed {
    logic [19:0] src;
    logic [19:0] dst;
    logic [19:0] wptr;
    logic [15:0] reload;
    logic [15:0] count;
    logic [15:0] ctrl;
    logic reload_pend;
    logic req;
    logic pin_prev;
  } tdc_chan_type;

  // Whole block state
  typedef struct packed {
    tdc_chan_type [1:0] ch;
    tdc_phase_type phase;
    logic [3:0] cyc;
    logic [1:0] irq_stat;
    logic [1:0] irq_en;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic bus_hold;
    logic xfer_chan;
    logic [19:0] xfer_src;
    logic [19:0] xfer_dst;
  } tdc_state_type;
endpackage

// [bench/tdc_cpu_model.sv]
`timescale 1ns/10ps
// Processor side of the shared bus: one access after each transfer
module tdc_cpu_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus sharing
  input wire logic bus_hold,
  input wire logic [3:0] lag,
  output logic cpu_access_done
);
  logic held; // Bus held last cycle
  logic busy; // Access under way
  logic [3:0] cnt; // Cycles spent on it

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held <= 1'b0;
      busy <= 1'b0;
      cnt <= 4'h0;
      cpu_access_done <= 1'b0;
    end else begin
      held <= bus_hold;
      cpu_access_done <= 1'b0;
      // Start only once the engine let go, never while it holds the bus
      if (held && !bus_hold) begin
        busy <= 1'b1;
        cnt <= 4'h0;
      end else if (busy) begin
        cnt <= cnt + 4'h1;
        // Slow answers stretch the gap between two transfers
        if (cnt >= lag) begin
          cpu_access_done <= 1'b1;
          busy <= 1'b0;
        end
      end
    end
  end
endmodule

// [bench/two_channel_dma_request_and_cycles_bench.sv]
`timescale 1ns/10ps
module two_channel_dma_request_and_cycles_bench;
  // Bus and block signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:2] periph_req = 6'h0;
  logic [1:0] external_request_pin = 2'h3; // Pins idle high
  logic cpu_access_done;
  logic bus_hold;
  logic xfer_chan;
  logic [19:0] xfer_src;
  logic [19:0] xfer_dst;
  logic irq;
  logic [3:0] lag = 4'h5; // Slow processor
  int n_fail = 0;
  int cmp_count = 0;
  logic err; // Last error flag
  logic [31:0] rd; // Last read word
  // Transfer log
  int nx = 0;
  int run = 0;
  int gap = 0;
  int lens[8];
  int gaps[8];
  logic chs[8];
  logic [19:0] srcs[8];
  logic [19:0] dsts[8];

  tdc_dma u_tdc_dma (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .periph_req(periph_req), .external_request_pin(external_request_pin),
    .cpu_access_done(cpu_access_done), .bus_hold(bus_hold), .xfer_chan(xfer_chan),
    .xfer_src(xfer_src), .xfer_dst(xfer_dst), .irq(irq));
  tdc_cpu_model u_tdc_cpu_model (.pclk(pclk), .presetn(presetn), .bus_hold(bus_hold),
    .lag(lag), .cpu_access_done(cpu_access_done));

  // Clock
  initial begin
    forever #5 pclk = ~pclk;
  end

  // Log length, channel, source and lead gap of each transfer
  always @(posedge pclk) begin
    if (bus_hold) begin
      if (run == 0) begin
        chs[nx] <= xfer_chan;
        srcs[nx] <= xfer_src;
        dsts[nx] <= xfer_dst;
        gaps[nx] <= gap;
      end
      run <= run + 1;
    end else if (run != 0) begin
      lens[nx] <= run;
      nx <= nx + 1;
      run <= 0;
      gap <= 0;
    end else begin
      gap <= gap + 1;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One transfer; an edge always passes before the setup cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a stalled wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // Irq is registered, let it settle
  task automatic ci(input logic e);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, {31'h0, e});
  endtask

  task automatic wait_nx(input int n);
    int t;
    t = 0;
    while (nx < n && t < 400) begin
      @(posedge pclk);
      t++;
    end
  endtask

  task automatic pulse;
    @(posedge pclk);
    periph_req[2] <= 1'b1;
    @(posedge pclk);
    periph_req[2] <= 1'b0;
  endtask

  // Reset values and an unmapped place
  task automatic t_regs;
    rc(8'h00, 32'h0);
    rc(8'h0c, 32'h0);
    apb(1'b0, 8'h80, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask

  // Flag on a disabled channel, software writes, merged requests
  task automatic t_flag;
    wr(8'h0c, 32'h40);
    wr(8'h40, 32'h0);
    pulse();
    pulse();
    rc(8'h40, 32'h1);
    wr(8'h40, 32'h3);
    rc(8'h40, 32'h1);
    wr(8'h0c, 32'h43);
    repeat (60) @(posedge pclk);
    chk(32'(nx), 32'h1);
    rc(8'h40, 32'h0);
    rc(8'h0c, 32'h43);
    rc(8'h00, 32'h2);
    rc(8'h10, 32'h0);
    wr(8'h0c, 32'h40);
    pulse();
    rc(8'h40, 32'h1);
    wr(8'h40, 32'h0);
    rc(8'h40, 32'h0);
  endtask

  // Both pins fall together: ordering, cycle counts, reloads
  task automatic t_pair;
    int b;
    b = nx;
    wr(8'h00, 32'h12345);
    wr(8'h04, 32'h00200);
    wr(8'h08, 32'h0);
    wr(8'h0c, 32'h620);
    wr(8'h20, 32'h00100);
    wr(8'h28, 32'h0);
    wr(8'h2c, 32'h1224);
    wr(8'h40, 32'h0);
    wr(8'h0c, 32'h621);
    wr(8'h2c, 32'h1225);
    wr(8'h04, 32'h00300);
    rc(8'h04, 32'h00200);
    @(posedge pclk);
    external_request_pin <= 2'h0;
    wait_nx(b + 2);
    external_request_pin <= 2'h3;
    chk(32'(nx), 32'(b + 2));
    chk({31'h0, chs[b]}, 32'h0);
    chk({31'h0, chs[b + 1]}, 32'h1);
    chk(32'(lens[b]), 32'h7);
    chk({12'h0, dsts[b]}, 32'h00200);
    chk(32'(lens[b + 1]), 32'h4);
    chk({12'h0, srcs[b]}, 32'h12345);
    chk({12'h0, srcs[b + 1]}, 32'h00100);
    chk({31'h0, gaps[b + 1] > 5}, 32'h1);
    rc(8'h0c, 32'h620);
    rc(8'h2c, 32'h1224);
  endtask

  // Sticky status, enable mask and clear
  task automatic t_irq;
    rc(8'h44, 32'h3);
    ci(1'b0);
    wr(8'h4c, 32'h1);
    ci(1'b1);
    wr(8'h48, 32'h1);
    rc(8'h44, 32'h2);
    ci(1'b0);
    wr(8'h4c, 32'h2);
    ci(1'b1);
    wr(8'h4c, 32'h0);
    ci(1'b0);
  endtask

  // Channel one: 8-bit bus, forward destination, both edges, restart, trigger
  task automatic t_more;
    int b;
    b = nx;
    wr(8'h48, 32'h2);
    wr(8'h20, 32'h00400);
    wr(8'h24, 32'h00801);
    wr(8'h28, 32'h1);
    wr(8'h2c, 32'h292b);
    wr(8'h40, 32'h0);
    external_request_pin <= 2'h1;
    wait_nx(b + 1);
    rc(8'h44, 32'h0);
    external_request_pin <= 2'h3;
    wait_nx(b + 2);
    rc(8'h44, 32'h2);
    rc(8'h2c, 32'h292b);
    rc(8'h30, 32'h1);
    rc(8'h24, 32'h00805);
    // Rewrite enable while active to restart
    wr(8'h2c, 32'h292b);
    external_request_pin <= 2'h1;
    wait_nx(b + 3);
    wr(8'h2c, 32'h280b);
    wr(8'h40, 32'h0);
    external_request_pin <= 2'h3;
    wr(8'h2c, 32'ha80b);
    wait_nx(b + 4);
    rc(8'h2c, 32'h280b);
    wr(8'h2c, 32'h0);
    chk(32'(nx), 32'(b + 4));
    chk(32'(lens[b]), 32'h6);
    chk(32'(lens[b + 1]), 32'h6);
    chk({12'h0, srcs[b]}, 32'h00400);
    chk({12'h0, dsts[b]}, 32'h00801);
    chk({12'h0, dsts[b + 1]}, 32'h00803);
    chk({12'h0, dsts[b + 2]}, 32'h00801);
    chk({12'h0, dsts[b + 3]}, 32'h00801);
  endtask

  task automatic summarize;
    $display("checks %0d failures %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_flag();
    t_pair();
    t_irq();
    t_more();
    summarize();
  end

  // Watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    summarize();
  end
endmodule
